//--- sac_ctrl_props.sv
/*
  assertions on the top ports of the slider speed and recal block.
  assumes one clock domain, bound to the top module below.
*/
`timescale 1ns/1ps
module sac_ctrl_props
#(
    parameter int MS_CYCLES = 10
)
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       measTick,
    input wire logic       sliderIrqIn,
    input wire logic       sliderIrq,
    input wire logic [7:0] recalDone,
    input wire logic [7:0] recalStart,
    input wire logic [7:0] recalBusy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_recal_wr;
        regWrEn && regAddr == sac_pkg::ADDR_RECAL;
    endsequence

    sequence s_recal_rd;
        regRdEn && regAddr == sac_pkg::ADDR_RECAL;
    endsequence

    a_recal_bit_set: assert property (s_recal_wr |=> (recalBusy & $past(regWrData)) == $past(regWrData))
        else $error("recal bits not set by write");
    a_busy_done_clear: assert property (recalDone != 8'h00 && !regWrEn |=> (recalBusy & $past(recalDone)) == 8'h00)
        else $error("recal bit not cleared after done");
    a_busy_write_cause: assert property ((recalBusy & ~$past(recalBusy)) != 8'h00 |-> $past(regWrEn && regAddr == sac_pkg::ADDR_RECAL))
        else $error("recal bit set without host write");
    a_start_not_busy: assert property (recalStart != 8'h00 |-> (recalStart & ~recalBusy) == 8'h00 && (recalStart & $past(recalBusy) & ~$past(recalDone)) == 8'h00)
        else $error("start pulse for busy or idle bit");
    a_poll_reads_busy: assert property (s_recal_rd |=> regRdData == $past(recalBusy))
        else $error("recal read differs from busy bits");
    a_read_data_held: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without read");
    a_irq_passes: assert property (sliderIrqIn |=> sliderIrq)
        else $error("ordinary slider interrupt lost");
    a_irq_has_cause: assert property (sliderIrq |-> $past(measTick || sliderIrqIn))
        else $error("slider interrupt without tick or input");
endmodule

bind sac_slider_accel_recal_ctrl sac_ctrl_props #(.MS_CYCLES(MS_CYCLES)) i_props
(
    .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .measTick(measTick), .sliderIrqIn(sliderIrqIn),
    .sliderIrq(sliderIrq), .recalDone(recalDone), .recalStart(recalStart), .recalBusy(recalBusy)
);

//--- sac_extra_irq_calc.sv
/*
  extra interrupt count from measured slide time and configuration.
  assumes slide time in whole milliseconds, saturated by the caller.
*/
`timescale 1ns/1ps
module sac_extra_irq_calc
(
    input  wire logic [2:0] extraIrqLimit,
    input  wire logic [1:0] slideTimeLimit,
    input  wire logic [9:0] slideMs,
    output logic      [2:0] extraCount
);
    logic [9:0]  limitMs;
    logic [11:0] twiceT;
    logic [11:0] fourT;
    logic [11:0] threeLim;

    always_comb
    begin
        unique case (slideTimeLimit)
            2'b00: limitMs = sac_pkg::SLIDE_MS_0;
            2'b01: limitMs = sac_pkg::SLIDE_MS_1;
            2'b10: limitMs = sac_pkg::SLIDE_MS_2;
            2'b11: limitMs = sac_pkg::SLIDE_MS_3;
        endcase
    end

    always_comb
    begin
        twiceT   = {1'b0, slideMs, 1'b0};
        fourT    = {slideMs, 2'b00};
        threeLim = {1'b0, limitMs, 1'b0} + {2'b00, limitMs};
        if (twiceT < {2'b00, limitMs})
            extraCount = extraIrqLimit;
        else if (fourT < threeLim)
            extraCount = {1'b0, extraIrqLimit[2:1]};
        else if (slideMs <= limitMs)
            extraCount = {2'b00, extraIrqLimit[2]};
        else
            extraCount = 3'h0;
    end
endmodule

//--- sac_pkg.sv
/*
  constants, field layout, reset values and state type for the slider
  acceleration and forced recalibration block.
  assumes one 200 MHz system clock and an internal register port.

// Notes on behaviour
// - accel enable set: extra interrupts after fast slide, count grows with speed, capped.
// - accel enable clear: no extra interrupts during or after any slide.
// - extra_irq_limit in bits 6-4, reset 100b, caps extras per slide.
// - under half limit: N; to three quarters: N/2; to full: N>=4.
// - slide_time_limit in bits 3-2, reset 01b; slower slides give no extras.
// - slide_time_limit selects 350, 560, 770 or 980 ms.
// - speed_repeat_scale in bits 1-0, reset 01b; speed counts sensors per 100 ms.
// - repeat interval from sensor count and scale; one sensor uses base repeat rate.
// - base rate at most 105 with scale 11b: fixed 140, 105, 70.
// - host sets force bit; device recalibrates channel and replaces base count.
// - bit 7 requests grouped sensors, bits 6..0 request channels 7..1.
// - force bit stays set while running, device clears it when done.
*/
package sac_pkg;

    localparam logic [7:0] ADDR_SPEED_CFG     = 8'h3E;
    localparam logic [7:0] ADDR_RECAL         = 8'h3F;
    localparam logic [7:0] SPEED_CFG_RESET    = 8'hC5;
    localparam logic [7:0] RECAL_RESET        = 8'h00;
    localparam logic [7:0] READ_ZERO          = 8'h00;

    localparam int ACC_EN_BIT       = 7;
    localparam int LIMIT_MSB        = 6;
    localparam int LIMIT_LSB        = 4;
    localparam int STIME_MSB        = 3;
    localparam int STIME_LSB        = 2;
    localparam int SCALE_MSB        = 1;
    localparam int SCALE_LSB        = 0;
    localparam int RECAL_W          = 8;
    localparam int SENSOR_W         = 7;

    localparam int CLK_PERIOD_NS    = 5;
    localparam int MS_NS            = 1000000;
    localparam int MS_CYCLES        = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int MS_W             = 10;
    localparam logic [9:0] MS_SAT   = 10'h3FF;
    localparam logic [9:0] SLIDE_MS_0 = 10'd350;
    localparam logic [9:0] SLIDE_MS_1 = 10'd560;
    localparam logic [9:0] SLIDE_MS_2 = 10'd770;
    localparam logic [9:0] SLIDE_MS_3 = 10'd980;
    localparam logic [6:0] SPEED_WINDOW_MS = 7'd100;

    localparam logic [7:0] REPEAT_35  = 8'd35;
    localparam logic [7:0] REPEAT_70  = 8'd70;
    localparam logic [7:0] REPEAT_105 = 8'd105;
    localparam logic [7:0] REPEAT_140 = 8'd140;
    localparam logic [7:0] FIXED_BASE_MAX = 8'd105;
    localparam logic [1:0] SCALE_FIXED    = 2'b11;

    typedef enum logic [1:0] {SL_IDLE, SL_TIMING, SL_ISSUE} sac_slide_state_t;

    function automatic logic [2:0] popcount7(input logic [6:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 7; i++)
        begin
            c = c + {2'b00, v[i]};
        end
        return c;
    endfunction

endpackage

//--- sac_recal_engine_model.sv
/*
  recal engine stand-in: answers each start pulse with a done pulse.
  assumes start pulses from the block on clk_sys; slowMode lengthens runs.
*/
`timescale 1ns/1ps
module sac_recal_engine_model
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [7:0] recalStart,
    input  wire logic       slowMode,
    output logic      [7:0] recalDone
);
    int cnt [8];

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < 8; i++)
        begin
            recalDone[i] <= resetn && cnt[i] == 1;
            if (!resetn)
                cnt[i] <= 0;
            else if (recalStart[i])
                cnt[i] <= slowMode ? 40 : 3;
            else if (cnt[i] > 0)
                cnt[i] <= cnt[i] - 1;
        end
    end
endmodule

//--- sac_repeat_interval.sv
/*
  slider repeat interval from sensors touched per window and scale.
  assumes base rate in measurement cycles.
*/
`timescale 1ns/1ps
module sac_repeat_interval
(
    input  wire logic [2:0] sensorCount,
    input  wire logic [1:0] speedRepeatScale,
    input  wire logic [7:0] sliderBaseRepeatRate,
    output logic      [7:0] repeatInterval
);
    logic fixedCase;
    logic [7:0] base;

    always_comb
    begin
        base      = sliderBaseRepeatRate;
        fixedCase = (sliderBaseRepeatRate <= sac_pkg::FIXED_BASE_MAX);
        repeatInterval = base;
        if (sensorCount >= 3'd5)
            repeatInterval = sac_pkg::REPEAT_35;
        else if (sensorCount >= 3'd2)
        begin
            unique case (speedRepeatScale)
                2'b00: repeatInterval = sac_pkg::REPEAT_35;
                2'b01: repeatInterval = (sensorCount == 3'd2) ? sac_pkg::REPEAT_70 : sac_pkg::REPEAT_35;
                2'b10: repeatInterval = (sensorCount == 3'd2) ? sac_pkg::REPEAT_105 :
                                        (sensorCount == 3'd3) ? sac_pkg::REPEAT_70 : sac_pkg::REPEAT_35;
                2'b11:
                begin
                    if (fixedCase)
                        repeatInterval = (sensorCount == 3'd2) ? sac_pkg::REPEAT_140 :
                                         (sensorCount == 3'd3) ? sac_pkg::REPEAT_105 : sac_pkg::REPEAT_70;
                    else
                        repeatInterval = (sensorCount == 3'd2) ? base :
                                         (sensorCount == 3'd3) ? (base - {2'b00, base[7:2]}) : {1'b0, base[7:1]};
                end
            endcase
        end
    end
endmodule

//--- sac_slider_accel_recal_ctrl.sv
/*
  slider speed configuration and forced recalibration control: registers,
  slide timing, extra interrupts, speed scaled repeats, recal handshake.
  assumes all inputs come from logic on clk_sys; measTick is one pulse per
  measurement cycle; recalDone pulses when the engine finishes a channel.
*/
`timescale 1ns/1ps
module sac_slider_accel_recal_ctrl
#(
    parameter int MS_CYCLES = sac_pkg::MS_CYCLES
)
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    input  wire logic       measTick,
    input  wire logic [6:0] sensorTouch,
    input  wire logic       slideStart,
    input  wire logic       slideEnd,
    input  wire logic       sliderHeld,
    input  wire logic       sliderIrqIn,
    input  wire logic [7:0] sliderBaseRepeatRate,
    output logic            sliderIrq,
    input  wire logic [7:0] recalDone,
    output logic      [7:0] recalStart,
    output logic      [7:0] recalBusy
);
    localparam int DIV_W = $clog2(MS_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

    logic [7:0]       speedCfg_reg;
    logic [7:0]       recal_reg;
    logic [7:0]       recal_next;
    logic [7:0]       rdData_reg;
    logic [7:0]       recalStart_reg;
    logic             sliderIrq_reg;
    logic [DIV_W-1:0] divCnt_reg;
    logic             msTick_reg;
    sac_pkg::sac_slide_state_t state_reg;
    logic [9:0]       slideMs_reg;
    logic [2:0]       extraLeft_reg;
    logic [6:0]       winMs_reg;
    logic [6:0]       touchedMask_reg;
    logic [2:0]       sensorCount_reg;
    logic [7:0]       repCnt_reg;

    logic             accelExtraIrqEnable;
    logic [2:0]       extraIrqLimit;
    logic [1:0]       slideTimeLimit;
    logic [1:0]       speedRepeatScale;
    logic [2:0]       extraCount;
    logic [7:0]       repeatInterval;
    logic             wrSpeed;
    logic             wrRecal;
    logic [7:0]       recalSet;
    logic             extraFire;
    logic             repeatFire;

    assign accelExtraIrqEnable = speedCfg_reg[sac_pkg::ACC_EN_BIT];
    assign extraIrqLimit       = speedCfg_reg[sac_pkg::LIMIT_MSB:sac_pkg::LIMIT_LSB];
    assign slideTimeLimit      = speedCfg_reg[sac_pkg::STIME_MSB:sac_pkg::STIME_LSB];
    assign speedRepeatScale    = speedCfg_reg[sac_pkg::SCALE_MSB:sac_pkg::SCALE_LSB];
    assign wrSpeed             = regWrEn && (regAddr == sac_pkg::ADDR_SPEED_CFG);
    assign wrRecal             = regWrEn && (regAddr == sac_pkg::ADDR_RECAL);
    assign recalSet            = wrRecal ? regWrData : sac_pkg::RECAL_RESET;

    sac_extra_irq_calc u_extra
    (
        .extraIrqLimit  (extraIrqLimit),
        .slideTimeLimit (slideTimeLimit),
        .slideMs        (slideMs_reg),
        .extraCount     (extraCount)
    );

    sac_repeat_interval u_repeat
    (
        .sensorCount          (sensorCount_reg),
        .speedRepeatScale     (speedRepeatScale),
        .sliderBaseRepeatRate (sliderBaseRepeatRate),
        .repeatInterval       (repeatInterval)
    );

    // configuration register
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            speedCfg_reg <= sac_pkg::SPEED_CFG_RESET;
        else if (wrSpeed)
            speedCfg_reg <= regWrData;
    end

    // force recalibration bits: host sets, engine done clears, set wins
    always_comb
    begin
        recal_next = (recal_reg & ~recalDone) | recalSet;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            recal_reg <= sac_pkg::RECAL_RESET;
        else
            recal_reg <= recal_next;
    end

    // start pulse for requested channels that are idle or finish this cycle
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            recalStart_reg <= sac_pkg::RECAL_RESET;
        else
            recalStart_reg <= recalSet & (~recal_reg | recalDone);
    end

    // register readback
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            rdData_reg <= sac_pkg::READ_ZERO;
        else if (regRdEn)
        begin
            if (regAddr == sac_pkg::ADDR_SPEED_CFG)
                rdData_reg <= speedCfg_reg;
            else if (regAddr == sac_pkg::ADDR_RECAL)
                rdData_reg <= recal_reg;
            else
                rdData_reg <= sac_pkg::READ_ZERO;
        end
    end

    // millisecond enable divider
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            divCnt_reg <= '0;
            msTick_reg <= 1'b0;
        end
        else if (divCnt_reg == DIV_LAST)
        begin
            divCnt_reg <= '0;
            msTick_reg <= 1'b1;
        end
        else
        begin
            divCnt_reg <= divCnt_reg + 1'b1;
            msTick_reg <= 1'b0;
        end
    end

    // slide timing and extra interrupt issue
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_reg     <= sac_pkg::SL_IDLE;
            slideMs_reg   <= '0;
            extraLeft_reg <= 3'h0;
        end
        else
        begin
            unique case (state_reg)
                sac_pkg::SL_IDLE:
                begin
                    if (slideStart)
                    begin
                        state_reg   <= sac_pkg::SL_TIMING;
                        slideMs_reg <= '0;
                    end
                end
                sac_pkg::SL_TIMING:
                begin
                    if (slideStart)
                        slideMs_reg <= '0;
                    else if (slideEnd)
                    begin
                        if (accelExtraIrqEnable && (extraCount != 3'h0))
                        begin
                            state_reg     <= sac_pkg::SL_ISSUE;
                            extraLeft_reg <= extraCount;
                        end
                        else
                            state_reg <= sac_pkg::SL_IDLE;
                    end
                    else if (msTick_reg && (slideMs_reg != sac_pkg::MS_SAT))
                        slideMs_reg <= slideMs_reg + 1'b1;
                end
                sac_pkg::SL_ISSUE:
                begin
                    if (slideStart)
                    begin
                        state_reg     <= sac_pkg::SL_TIMING;
                        slideMs_reg   <= '0;
                        extraLeft_reg <= 3'h0;
                    end
                    else if (!accelExtraIrqEnable)
                    begin
                        state_reg     <= sac_pkg::SL_IDLE;
                        extraLeft_reg <= 3'h0;
                    end
                    else if (measTick)
                    begin
                        extraLeft_reg <= extraLeft_reg - 1'b1;
                        if (extraLeft_reg == 3'h1)
                            state_reg <= sac_pkg::SL_IDLE;
                    end
                end
            endcase
        end
    end

    assign extraFire = (state_reg == sac_pkg::SL_ISSUE) && accelExtraIrqEnable && measTick && !slideStart;

    // sensors touched per speed window
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !sliderHeld)
        begin
            winMs_reg       <= '0;
            touchedMask_reg <= '0;
            sensorCount_reg <= 3'h0;
        end
        else if (msTick_reg && (winMs_reg == sac_pkg::SPEED_WINDOW_MS - 7'd1))
        begin
            winMs_reg       <= '0;
            touchedMask_reg <= '0;
            sensorCount_reg <= sac_pkg::popcount7(touchedMask_reg | sensorTouch);
        end
        else
        begin
            if (msTick_reg)
                winMs_reg <= winMs_reg + 7'd1;
            touchedMask_reg <= touchedMask_reg | sensorTouch;
        end
    end

    // speed scaled repeat counter in measurement cycles
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !sliderHeld || sliderIrqIn)
            repCnt_reg <= '0;
        else if (measTick)
        begin
            if (repeatFire)
                repCnt_reg <= '0;
            else
                repCnt_reg <= repCnt_reg + 8'd1;
        end
    end

    assign repeatFire = sliderHeld && !sliderIrqIn && measTick && (repeatInterval != 8'd0) &&
                        ((repCnt_reg + 8'd1) >= repeatInterval);

    // one slider interrupt path for ordinary, extra and repeat events
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            sliderIrq_reg <= 1'b0;
        else
            sliderIrq_reg <= sliderIrqIn | extraFire | repeatFire;
    end

    assign regRdData  = rdData_reg;
    assign sliderIrq  = sliderIrq_reg;
    assign recalStart = recalStart_reg;
    assign recalBusy  = recal_reg;
endmodule

//--- sac_slider_accel_recal_ctrl_bench.sv
/*
  self-checking bench for the slider speed and recal block.
  assumes MS_CYCLES of 10, base repeat rate 36 to 105, tick every second cycle.
*/
`timescale 1ns/1ps
module sac_slider_accel_recal_ctrl_bench;
    logic       clk_sys, resetn, regWrEn, regRdEn, measTick, slideStart, slideEnd;
    logic       sliderHeld, sliderIrqIn, sliderIrq, slowMode;
    logic [7:0] regAddr, regWrData, regRdData, recalDone, recalStart, recalBusy;
    logic [6:0] sensorTouch;
    logic [7:0] baseRate;
    int         bad_count, num_checks;

    sac_slider_accel_recal_ctrl #(.MS_CYCLES(10)) i_dut
    (
        .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .measTick(measTick), .sensorTouch(sensorTouch),
        .slideStart(slideStart), .slideEnd(slideEnd), .sliderHeld(sliderHeld), .sliderIrqIn(sliderIrqIn),
        .sliderBaseRepeatRate(baseRate), .sliderIrq(sliderIrq), .recalDone(recalDone),
        .recalStart(recalStart), .recalBusy(recalBusy)
    );

    sac_recal_engine_model i_eng
    (
        .clk_sys(clk_sys), .resetn(resetn), .recalStart(recalStart), .slowMode(slowMode), .recalDone(recalDone)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        measTick = 1'b0;
        forever @(negedge clk_sys) measTick = ~measTick;
    end

    task automatic results;
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        d = regRdData;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        while (sliderIrq !== 1'b1)
        begin
            if (n == 2000)
            begin
                bad_count++;
                results();
            end
            cyc(1);
            n++;
        end
    endtask

    function automatic int extra_exp(input logic [7:0] c, input int t);
        int n, lim;
        n = c[6:4];
        lim = 350 + 210 * c[3:2];
        if (!c[7]) return 0;
        if (t * 2 < lim) return n;
        if (t * 4 < 3 * lim) return n >> 1;
        if (t <= lim) return n >> 2;
        return 0;
    endfunction

    function automatic int rep_exp(input int k, input int s);
        if (k <= 1) return baseRate;
        if (k >= 5) return 35;
        return 35 * ((s + 3 - k < 1) ? 1 : s + 3 - k);
    endfunction

    initial
    begin
        logic [7:0] d, cfg, m;
        int t, n, g, k, s;
        {resetn, regWrEn, regRdEn, slideStart, slideEnd, sliderHeld, sliderIrqIn, slowMode} = 8'h00;
        {regAddr, regWrData} = 16'h0000;
        sensorTouch = 7'h00;
        bad_count = 0;
        num_checks = 0;
        void'($urandom(32'hD2D934FF));
        baseRate = 8'($urandom_range(36, 105));
        cyc(10);
        resetn = 1'b1;
        rd(sac_pkg::ADDR_SPEED_CFG, d);
        chk("speed cfg reset", sac_pkg::SPEED_CFG_RESET, d);
        rd(sac_pkg::ADDR_RECAL, d);
        chk("recal reset", sac_pkg::RECAL_RESET, d);
        m = 8'h40 + 8'($urandom_range(0, 61));
        wr(m, 8'hFF);
        rd(m, d);
        chk("unmapped read", 8'h00, d);
        pulse(sliderIrqIn);
        chk("ordinary irq", 1'b1, sliderIrq);
        for (int i = 0; i < 6; i++)
        begin
            cfg = 8'($urandom);
            cfg[7] = (i != 0);
            if (cfg[6:4] == 3'h0) cfg[4] = 1'b1;
            t = (350 + 210 * cfg[3:2]) * (25 + 35 * (i % 4)) / 100;
            wr(sac_pkg::ADDR_SPEED_CFG, cfg);
            rd(sac_pkg::ADDR_SPEED_CFG, d);
            chk("speed cfg", cfg, d);
            pulse(slideStart);
            cyc(t * 10);
            pulse(slideEnd);
            n = 0;
            repeat (40)
            begin
                cyc(1);
                n += (sliderIrq === 1'b1);
            end
            chk("extra irqs", extra_exp(cfg, t), n);
        end
        sliderHeld = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            k = 1 + i % 5;
            s = (i * 3) % 4;
            wr(sac_pkg::ADDR_SPEED_CFG, {cfg[7:2], 2'(s)});
            sensorTouch = 7'(((1 << k) - 1) << $urandom_range(0, 7 - k));
            cyc(2100);
            wait_irq(n);
            cyc(1);
            wait_irq(g);
            chk("repeat gap", 2 * rep_exp(k, s), g + 1);
        end
        sliderHeld = 1'b0;
        slowMode = 1'b1;
        m = 8'($urandom_range(1, 255));
        wr(sac_pkg::ADDR_RECAL, m);
        chk("recal start", m, recalStart);
        chk("recal busy", m, recalBusy);
        wr(sac_pkg::ADDR_RECAL, 8'h00);
        rd(sac_pkg::ADDR_RECAL, d);
        chk("recal held", m, d);
        wr(sac_pkg::ADDR_RECAL, m);
        chk("recal refused", 8'h00, recalStart);
        n = 0;
        while (d !== 8'h00)
        begin
            if (n == 100)
            begin
                bad_count++;
                results();
            end
            rd(sac_pkg::ADDR_RECAL, d);
            n++;
        end
        chk("recal cleared", 8'h00, recalBusy);
        slowMode = 1'b0;
        wr(sac_pkg::ADDR_RECAL, 8'hFF);
        chk("recal all start", 8'hFF, recalStart);
        cyc(8);
        chk("recal all done", 8'h00, recalBusy);
        results();
    end
endmodule
